// ---- pmr_map.svh ----
// offsets, field positions, reset values and timing counts of the power monitor
`ifndef PMR_MAP_SVH
`define PMR_MAP_SVH
`define PMR_CFG_AVG_LSB 0
`define PMR_CFG_SHDN_BIT 4
`define PMR_CFG_EXT_BIT 5
`define PMR_CFG_QTY_LSB 6
`define PMR_CFG_ALERT_BIT 8
`define PMR_CFG_THR_LSB 9
`define PMR_CFG_RESET 16'h0000
`define PMR_ADDR_LOW 7'h70
`define PMR_ADDR_OPEN 7'h72
`define PMR_ADDR_HIGH 7'h76
`define PMR_AVG_N_MAX 4'h8
`define PMR_FULL_COUNT 256
`define PMR_CLK_HZ 40000000
`define PMR_INT_SAMPLE_KHZ 512
`define PMR_INT_DIV (`PMR_CLK_HZ / (`PMR_INT_SAMPLE_KHZ * 1000))
`define PMR_INT_LOG2 9
`define PMR_EXT_MIN_KHZ 922
`define PMR_EXT_LOSS_CYC (2 * `PMR_CLK_HZ / (`PMR_EXT_MIN_KHZ * 1000))
`define PMR_SCL_MIN_KHZ 10
`define PMR_SCL_MAX_KHZ 400
`endif

// ---- pmr_pkg.sv ----
// types shared by the power monitor result report block
package pmr_pkg;
	typedef enum logic [1:0] {
		PMR_Q_POWER,
		PMR_Q_VOLTAGE,
		PMR_Q_CURRENT,
		PMR_Q_UNDEF
	} pmr_quantity_e;
	typedef enum logic [1:0] {
		PMR_STRAP_LOW,
		PMR_STRAP_OPEN,
		PMR_STRAP_HIGH
	} pmr_strap_e;
	typedef struct packed {
		logic [6:0] threshold;
		logic alert_thr;
		pmr_quantity_e quantity;
		logic ext_tb;
		logic shutdown;
		logic [3:0] avg_n;
	} pmr_cfg_s;
	typedef struct packed {
		logic signed [9:0] current;
		logic [8:0] voltage;
	} pmr_sample_s;
endpackage

// ---- pmr_link.sv ----
// serial bus slave on the link clock: address match and two-byte result read
`timescale 1ns/1ps
module pmr_link import pmr_pkg::*; (
	input wire logic link_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic [6:0] slave_address,
	input wire logic addr_ready,
	input wire logic [15:0] result_word,
	input wire logic result_tgl,
	output logic sda_out,
	output logic sda_oe,
	output logic read_done_tgl
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WRITE, ST_READ, ST_ACK_READ
	} pmr_link_state_e;
	pmr_link_state_e state;
	logic [2:0] scl_s, sda_s, rtg_s;
	logic [1:0] ardy_s;
	logic [6:0] my_addr;
	logic [15:0] shadow, tx;
	logic [7:0] shreg;
	logic [3:0] bit_cnt;
	logic byte_idx, nack;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic [1:0] rst_s;
	logic link_rst;

	// scl is only ever sampled, never driven
	assign sda_out = 1'b0;
	// link clock oversamples scl far above the slowest and fastest bus rates
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			rtg_s <= 3'h0;
			ardy_s <= 2'h0;
			rst_s <= 2'h3;
		end else begin
			rst_s <= {rst_s[0], 1'b0};
			scl_s <= {scl_s[1:0], scl_in};
			sda_s <= {sda_s[1:0], sda_in};
			rtg_s <= {rtg_s[1:0], result_tgl};
			ardy_s <= {ardy_s[0], addr_ready};
		end
	end
	// reset release is retimed to the link clock; it is asserted at once
	assign link_rst = rst_s[1];
	assign scl_rise = scl_s[1] & ~scl_s[2];
	assign scl_fall = ~scl_s[1] & scl_s[2];
	assign start_c = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
	assign stop_c = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

	// address word is static once the ready level has crossed
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			my_addr <= 7'h00;
		end else if (ardy_s[1]) begin
			my_addr <= slave_address;
		end
	end
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			shadow <= 16'h0000;
		end else if (rtg_s[2] != rtg_s[1]) begin
			shadow <= result_word;
		end
	end

	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			state <= ST_IDLE;
			sda_oe <= 1'b0;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			tx <= 16'h0000;
			byte_idx <= 1'b0;
			nack <= 1'b0;
			read_done_tgl <= 1'b0;
		end else if (start_c) begin
			state <= ST_ADDR;
			sda_oe <= 1'b0;
			bit_cnt <= 4'h0;
		end else if (stop_c) begin
			state <= ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (state)
				ST_ADDR, ST_WRITE: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_s[1]};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						if (state == ST_WRITE) begin
							sda_oe <= 1'b1;
							state <= ST_ACK_WRITE;
						end else if (ardy_s[1] && shreg[7:1] == my_addr) begin
							sda_oe <= 1'b1;
							state <= ST_ACK_ADDR;
							// snapshot keeps both bytes from one result
							tx <= shadow;
							byte_idx <= 1'b0;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_ACK_ADDR: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (shreg[0]) begin
							state <= ST_READ;
							sda_oe <= ~tx[15];
							tx <= {tx[14:0], 1'b0};
						end else begin
							state <= ST_WRITE;
							sda_oe <= 1'b0;
						end
					end
				end
				ST_ACK_WRITE: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						bit_cnt <= 4'h0;
						state <= ST_WRITE;
					end
				end
				ST_READ: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							sda_oe <= 1'b0;
							state <= ST_ACK_READ;
						end else begin
							sda_oe <= ~tx[15];
							tx <= {tx[14:0], 1'b0};
						end
					end
				end
				ST_ACK_READ: begin
					if (scl_rise) begin
						nack <= sda_s[1];
						byte_idx <= 1'b1;
						if (byte_idx) begin
							read_done_tgl <= ~read_done_tgl;
						end
					end else if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (nack) begin
							state <= ST_IDLE;
						end else begin
							state <= ST_READ;
							sda_oe <= ~tx[15];
							tx <= {tx[14:0], 1'b0};
						end
					end
				end
				default: begin
					sda_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ---- pmr_top.sv ----
// power monitor result report: averaging, result formatting, attention output
// Function
// - new-data mode pulls attention low on result
// - completed result read releases attention output in new-data mode
// - threshold mode pulls low when result exceeds threshold
// - strap level selects one of three addresses
// - internal oscillator used without external timebase
// - serial clock from 10 to 400 kHz
// - slave only, serial clock is input only
// - data line sampled on writes, driven on reads
// - current is nulling over reference, 256 counts
// - current counts two's complement, -256 to 256
// - forward flow positive, reverse flow negative
// - voltage counts non-negative, voltage*256 over full scale
// - power counts signed, -256 to 256
// - config bit 8 selects attention mode
// - threshold bits 15..9 versus result without LSBs
// - config bits 7..6 select reported quantity
// - config bit 5 enables external timebase
`timescale 1ns/1ps
`include "pmr_map.svh"
module pmr_top import pmr_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire pmr_cfg_s cfg,
	input wire pmr_sample_s sample,
	input wire logic strap_hi_sense,
	input wire logic strap_lo_sense,
	input wire logic external_timebase_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic alert_out,
	output logic alert_oe,
	output logic sample_strobe,
	output logic [15:0] result,
	output logic result_new,
	output logic [6:0] slave_address,
	output logic timebase_external
);
	logic [1:0] strap_hi_s, strap_lo_s, ext_s;
	logic ext_d;
	logic ext_rise;
	logic [1:0] strap_wait;
	logic addr_ready;
	logic addr_valid;
	pmr_strap_e strap;
	logic [7:0] ext_loss_cnt;
	logic ext_present;
	logic [6:0] int_div;
	logic int_tick;
	logic use_ext;
	pmr_cfg_s cfg_run;
	logic ext_run;
	logic [18:0] samp_cnt;
	logic [4:0] shift;
	logic interval_end;
	logic signed [19:0] product;
	logic signed [11:0] value;
	logic signed [31:0] acc;
	logic signed [31:0] next_acc;
	logic signed [31:0] avg;
	logic signed [15:0] next_result;
	logic result_tgl;
	logic read_done_tgl;
	logic [2:0] rd_s;
	logic read_done;
	logic new_pend;
	logic above;

	// pins from outside are synchronised before any logic sees them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_hi_s <= 2'h0;
			strap_lo_s <= 2'h0;
			ext_s <= 2'h0;
			ext_d <= 1'b0;
		end else begin
			strap_hi_s <= {strap_hi_s[0], strap_hi_sense};
			strap_lo_s <= {strap_lo_s[0], strap_lo_sense};
			ext_s <= {ext_s[0], external_timebase_in};
			ext_d <= ext_s[1];
		end
	end
	assign ext_rise = ext_s[1] & ~ext_d;

	// strap is caught once, after the synchronisers have filled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_wait <= 2'h0;
			addr_ready <= 1'b0;
			strap <= PMR_STRAP_OPEN;
		end else if (!addr_ready) begin
			strap_wait <= strap_wait + 2'h1;
			if (strap_wait == 2'h3) begin
				addr_ready <= 1'b1;
				if (strap_lo_s[1] && !strap_hi_s[1]) begin
					strap <= PMR_STRAP_LOW;
				end else if (strap_hi_s[1] && !strap_lo_s[1]) begin
					strap <= PMR_STRAP_HIGH;
				end else begin
					strap <= PMR_STRAP_OPEN;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slave_address <= `PMR_ADDR_OPEN;
			addr_valid <= 1'b0;
		end else begin
			// ready rises with the address word, never ahead of it
			addr_valid <= addr_ready;
			case (strap)
				PMR_STRAP_LOW: slave_address <= `PMR_ADDR_LOW;
				PMR_STRAP_HIGH: slave_address <= `PMR_ADDR_HIGH;
				default: slave_address <= `PMR_ADDR_OPEN;
			endcase
		end
	end

	// external timebase counts as absent after two slowest periods without an edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_loss_cnt <= 8'(`PMR_EXT_LOSS_CYC);
		end else if (ext_rise) begin
			ext_loss_cnt <= 8'h00;
		end else if (ext_loss_cnt != 8'(`PMR_EXT_LOSS_CYC)) begin
			ext_loss_cnt <= ext_loss_cnt + 8'h01;
		end
	end
	assign ext_present = ext_loss_cnt != 8'(`PMR_EXT_LOSS_CYC);
	assign use_ext = cfg.ext_tb & ext_present;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_div <= 7'h00;
		end else if (int_div == 7'(`PMR_INT_DIV - 1)) begin
			int_div <= 7'h00;
		end else begin
			int_div <= int_div + 7'h01;
		end
	end
	assign int_tick = int_div == 7'(`PMR_INT_DIV - 1);

	// shutdown stops sampling and so freezes the result register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sample_strobe <= 1'b0;
			timebase_external <= 1'b0;
		end else begin
			sample_strobe <= ~cfg.shutdown & (use_ext ? ext_rise : int_tick);
			timebase_external <= use_ext;
		end
	end

	// averaging, quantity and sample count are taken at interval start; the strobe source follows cfg.ext_tb at once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_run <= pmr_cfg_s'(`PMR_CFG_RESET);
			ext_run <= 1'b0;
		end else if (sample_strobe && samp_cnt == 19'h00000) begin
			cfg_run <= cfg;
			ext_run <= use_ext;
			if (cfg.avg_n > `PMR_AVG_N_MAX) begin
				cfg_run.avg_n <= `PMR_AVG_N_MAX;
			end
		end
	end

	// 2^N ms holds 2^(N+9) internal or 2^(N+10) external samples
	always_comb begin
		if (samp_cnt == 19'h00000) begin
			shift = 5'(((cfg.avg_n > `PMR_AVG_N_MAX) ? `PMR_AVG_N_MAX : cfg.avg_n)
				+ `PMR_INT_LOG2) + {4'h0, use_ext};
		end else begin
			shift = 5'(cfg_run.avg_n + `PMR_INT_LOG2) + {4'h0, ext_run};
		end
	end
	assign interval_end = sample_strobe && samp_cnt == 19'((19'h1 << shift) - 19'h1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			samp_cnt <= 19'h00000;
		end else if (interval_end) begin
			samp_cnt <= 19'h00000;
		end else if (sample_strobe) begin
			samp_cnt <= samp_cnt + 19'h00001;
		end
	end

	// current is already nulling current in 1/256 of reference; sign marks flow
	assign product = 20'(sample.current * $signed({1'b0, sample.voltage}));
	always_comb begin
		pmr_quantity_e q;
		q = (samp_cnt == 19'h00000) ? cfg.quantity : cfg_run.quantity;
		case (q)
			PMR_Q_VOLTAGE: value = $signed({3'h0, sample.voltage});
			PMR_Q_CURRENT: value = 12'(sample.current);
			// undefined code falls back to power rather than inventing a quantity
			default: value = 12'(product >>> 8);
		endcase
	end

	assign next_acc = ((samp_cnt == 19'h00000) ? 32'sh0 : acc) + 32'(value);
	assign avg = next_acc >>> shift;

	always_comb begin
		logic signed [31:0] lo;
		lo = -32'sd256;
		if (cfg_run.quantity == PMR_Q_VOLTAGE && samp_cnt != 19'h00000) begin
			lo = 32'sh0;
		end
		if (avg > 32'sd256) begin
			next_result = 16'sd256;
		end else if (avg < lo) begin
			next_result = 16'(lo);
		end else begin
			next_result = 16'(avg);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc <= 32'sh0;
		end else if (sample_strobe) begin
			acc <= next_acc;
		end
	end

	// whole word replaced in one edge; the link side copies it only after the toggle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result <= 16'h0000;
			result_new <= 1'b0;
			result_tgl <= 1'b0;
		end else begin
			result_new <= interval_end;
			if (interval_end) begin
				result <= next_result;
				result_tgl <= ~result_tgl;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_s <= 3'h0;
		end else begin
			rd_s <= {rd_s[1:0], read_done_tgl};
		end
	end
	assign read_done = rd_s[2] ^ rd_s[1];

	// a new result in the same cycle as a read keeps the pending flag set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			new_pend <= 1'b0;
		end else if (result_new) begin
			new_pend <= 1'b1;
		end else if (read_done) begin
			new_pend <= 1'b0;
		end
	end

	assign above = $signed(result[15:2]) > $signed({7'h00, cfg.threshold});

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alert_oe <= 1'b0;
		end else if (cfg.alert_thr) begin
			alert_oe <= above;
		end else begin
			alert_oe <= new_pend;
		end
	end
	assign alert_out = 1'b0;

	pmr_link u_link (
		.link_clk(link_clk),
		.rst(rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.slave_address(slave_address),
		.addr_ready(addr_valid),
		.result_word(result),
		.result_tgl(result_tgl),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.read_done_tgl(read_done_tgl)
	);
endmodule

// ---- pmr_props.sv ----
// checker on the ports of the power monitor result report block
`timescale 1ns/1ps
module pmr_props import pmr_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire pmr_cfg_s cfg,
	input wire logic external_timebase_in,
	input wire logic scl_in,
	input wire logic sda_oe,
	input wire logic alert_oe,
	input wire logic sample_strobe,
	input wire logic [15:0] result,
	input wire logic result_new,
	input wire logic timebase_external
);
	a_new_pull: assert property (@(posedge clk) disable iff (rst)
		result_new && !cfg.alert_thr ##1 !cfg.alert_thr |=> alert_oe)
		else $error("attention not pulled after new result");
	// the mode guard looks two back because the output lags the mode by one cycle
	a_read_release: assert property (@(posedge clk) disable iff (rst)
		$fell(alert_oe) && !cfg.alert_thr && !$past(cfg.alert_thr)
		&& !$past(cfg.alert_thr, 2) |-> scl_in && !sda_oe)
		else $error("attention released outside a read");
	a_thr_level: assert property (@(posedge clk) disable iff (rst)
		cfg.alert_thr && $past(cfg.alert_thr) && !$past(result[15])
		|-> alert_oe == ($past(result[8:2]) > $past(cfg.threshold)))
		else $error("attention differs from threshold compare");
	a_result_range: assert property (@(posedge clk) disable iff (rst)
		$signed(result) >= -256 && $signed(result) <= 256)
		else $error("result out of range");
	a_result_atomic: assert property (@(posedge clk) disable iff (rst)
		$changed(result) |-> result_new)
		else $error("result changed without new flag");
	a_sda_change: assert property (@(posedge link_clk) disable iff (rst)
		$changed(sda_oe) |-> !scl_in)
		else $error("data line changed while clock high");
	a_ext_strobe: assert property (@(posedge clk) disable iff (rst)
		sample_strobe && timebase_external && $past(timebase_external)
		|-> ($past(external_timebase_in, 2) && !$past(external_timebase_in, 3))
		|| ($past(external_timebase_in, 3) && !$past(external_timebase_in, 4))
		|| ($past(external_timebase_in, 4) && !$past(external_timebase_in, 5)))
		else $error("external strobe without timebase edge");
	a_int_gap: assert property (@(posedge clk) disable iff (rst)
		sample_strobe && !timebase_external ##1 !result_new |-> !sample_strobe [*7])
		else $error("internal strobes too close");
	c_new: cover property (@(posedge clk) result_new && !cfg.alert_thr);
	c_thr: cover property (@(posedge clk) alert_oe && cfg.alert_thr);
	c_ext: cover property (@(posedge clk) sample_strobe && timebase_external);
endmodule
bind pmr_top pmr_props u_props (.clk, .rst, .link_clk, .cfg, .external_timebase_in, .scl_in,
	.sda_oe, .alert_oe, .sample_strobe, .result, .result_new, .timebase_external);

// ---- pmr_host.sv ----
// serial bus master model reading the two result bytes
`timescale 1ns/1ps
module pmr_host (
	output logic scl,
	output logic sda_oe,
	input wire logic sda
);
	localparam int HALF = 1250;
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	task automatic put_bit(input logic b);
		sda_oe = !b;
		#(HALF / 2) scl = 1'b1;
		#HALF scl = 1'b0;
		#(HALF / 2);
	endtask
	task automatic get_bit(output logic b);
		sda_oe = 1'b0;
		#(HALF / 2) scl = 1'b1;
		#(HALF / 2) b = sda;
		#(HALF / 2) scl = 1'b0;
		#(HALF / 2);
	endtask
	task automatic read_word(input logic [6:0] addr, output logic ack, output logic [15:0] word);
		logic [7:0] ab;
		logic b;
		ab = {addr, 1'b1};
		word = 16'hffff;
		sda_oe = 1'b1;
		#HALF scl = 1'b0;
		#(HALF / 2);
		for (int i = 7; i >= 0; i--) put_bit(ab[i]);
		get_bit(b);
		ack = !b;
		if (ack) begin
			for (int i = 15; i >= 0; i--) begin
				get_bit(word[i]);
				if (i == 8) put_bit(1'b0);
			end
			// no-acknowledge on the last byte ends the read
			put_bit(1'b1);
		end
		sda_oe = 1'b1;
		#(HALF / 2) scl = 1'b1;
		#HALF sda_oe = 1'b0;
		#HALF;
	endtask
endmodule

// ---- pmr_top_bench.sv ----
// self-checking bench for the power monitor result report block
`timescale 1ns/1ps
module pmr_top_bench import pmr_pkg::*; ;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic link_clk = 1'b0;
	logic ext_in = 1'b0;
	logic strap_hi = 1'b0;
	logic strap_lo = 1'b0;
	logic fix = 1'b0;
	pmr_cfg_s cfg = '0;
	pmr_sample_s sample = '0;
	wire logic scl;
	wire logic host_oe;
	wire logic sda_oe;
	wire logic sda_pin;
	wire logic alert_pin;
	wire logic tb_ext;
	wire logic sda_line = !host_oe && (!sda_oe || sda_pin);
	wire logic alert_oe;
	wire logic sample_strobe;
	wire logic result_new;
	wire logic [15:0] result;
	wire logic [6:0] slave_address;
	int fails = 0;
	int checked = 0;
	int nres = 0;
	int n = 0;
	int acc = 0;
	logic [15:0] last_exp = '0;
	pmr_quantity_e q = PMR_Q_POWER;
	logic ex = 1'b0;
	logic ack;
	logic [15:0] word;
	logic [1:0] strap_tab [3] = '{2'b00, 2'b10, 2'b01};
	logic [6:0] addr_tab [3] = '{7'h72, 7'h76, 7'h70};
	always #12.5 clk = ~clk;
	always #3 link_clk = ~link_clk;
	// timebase far above the nominal rate keeps each external interval short
	always #125 ext_in = ~ext_in;
	pmr_top uut (.clk(clk), .rst(rst), .link_clk(link_clk), .cfg(cfg), .sample(sample),
		.strap_hi_sense(strap_hi), .strap_lo_sense(strap_lo), .external_timebase_in(ext_in),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_pin), .sda_oe(sda_oe),
		.alert_out(alert_pin), .alert_oe(alert_oe), .sample_strobe(sample_strobe),
		.result(result), .result_new(result_new), .slave_address(slave_address),
		.timebase_external(tb_ext));
	pmr_host host (.scl(scl), .sda_oe(host_oe), .sda(sda_line));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		if (fails == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wait_res(input int k);
		for (int i = 0; i < 60000 && nres < k; i++) @(negedge clk);
		if (nres < k) begin
			fails++;
			test_done;
		end
	endtask
	function automatic int value(pmr_sample_s s, pmr_quantity_e qs);
		int c;
		int v;
		c = $signed(s.current);
		v = s.voltage;
		case (qs)
			PMR_Q_VOLTAGE: return v;
			PMR_Q_CURRENT: return c;
			default: return (c * v) >>> 8;
		endcase
	endfunction
	function automatic int clamp(int a, pmr_quantity_e qs);
		int lo;
		lo = (qs == PMR_Q_VOLTAGE) ? 0 : -256;
		return a < lo ? lo : (a > 256 ? 256 : a);
	endfunction
	always @(posedge clk) begin
		if (rst) begin
			n = 0;
			acc = 0;
		end else begin
			if (sample_strobe) begin
				if (n == 0) begin
					q = cfg.quantity;
					ex = cfg.ext_tb;
				end
				acc += value(sample, q);
				n++;
			end
			if (result_new) begin
				last_exp = 16'(clamp(acc >>> (ex ? 10 : 9), q));
				check("samples", 16'(n), ex ? 16'd1024 : 16'd512);
				check("result", result, last_exp);
				n = 0;
				acc = 0;
				nres++;
			end
		end
	end
	initial begin
		void'($urandom(15096));
		// the sample source is forked after seeding so its draws follow the seed
		fork
			forever begin
				@(posedge clk);
				if (fix) sample <= '{-10'sd256, 9'd256};
				else sample <= '{10'($urandom_range(512) - 256), 9'($urandom_range(256))};
			end
		join_none
		cfg <= '{7'h00, 1'b0, PMR_Q_VOLTAGE, 1'b0, 1'b0, 4'h0};
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			{strap_hi, strap_lo} <= strap_tab[i];
			rst <= 1'b1;
			repeat (6) @(posedge clk);
			rst <= 1'b0;
			repeat (8) @(posedge clk);
			@(negedge clk);
			check("address", {9'h000, slave_address}, {9'h000, addr_tab[i]});
		end
		wait_res(1);
		// attention follows the new-result pulse by two registers
		repeat (2) @(negedge clk);
		check("attention", {15'h0, alert_oe}, 16'h0001);
		check("pin levels", {14'h0, alert_pin, sda_pin}, 16'h0000);
		check("int timebase", {15'h0, tb_ext}, 16'h0000);
		@(posedge clk);
		cfg.quantity <= PMR_Q_POWER;
		cfg.ext_tb <= 1'b1;
		host.read_word(7'h72, ack, word);
		@(negedge clk);
		check("stray ack", {15'h0, ack}, 16'h0000);
		check("attention", {15'h0, alert_oe}, 16'h0001);
		host.read_word(7'h70, ack, word);
		@(negedge clk);
		check("ack", {15'h0, ack}, 16'h0001);
		check("read", word, last_exp);
		repeat (20) @(negedge clk);
		check("attention", {15'h0, alert_oe}, 16'h0000);
		@(posedge clk);
		cfg.alert_thr <= 1'b1;
		cfg.threshold <= last_exp[8:2] - 7'h01;
		repeat (4) @(negedge clk);
		check("over", {15'h0, alert_oe}, {15'h0, last_exp[8:2] != 7'h00});
		@(posedge clk);
		cfg.threshold <= last_exp[8:2];
		repeat (4) @(negedge clk);
		check("at threshold", {15'h0, alert_oe}, 16'h0000);
		@(posedge clk);
		cfg.alert_thr <= 1'b0;
		cfg.quantity <= PMR_Q_CURRENT;
		fix <= 1'b1;
		wait_res(3);
		check("reverse full scale", result, 16'hff00);
		check("ext timebase", {15'h0, tb_ext}, 16'h0001);
		test_done;
	end
endmodule
